// File: msc_mem_size_cfg.sv
// Memory size configuration registers and their capacity decode.
// Assumes byte accesses from the local processor on sys_clk.
`timescale 1ns/1ns
module msc_mem_size_cfg
  import msc_pkg::*;
#(
  parameter logic [16:0] EXP_RAM_BASE = MSC_EXP_BASE_DEFAULT  // Expansion window start
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Processor byte bus
  input  wire msc_bus_req_t bus_req,
  output logic              rd_valid,
  output logic              rd_hit,
  output logic        [7:0] rd_data,
  // Decoded capacities
  output msc_cfg_t          mem_cfg,
  // Configuration status
  output logic              order_error,
  output logic              cfg_done
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // The window must sit inside the 64 KB space and on a 1 KB boundary
  if (EXP_RAM_BASE > 17'h10000 || EXP_RAM_BASE[9:0] != 10'h000)
  begin : g_bad_base
    $error("msc_mem_size_cfg: expansion base out of range or unaligned");
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic       sel_main;          // Main register addressed
  logic       sel_exp;           // Expansion register addressed
  logic       wr_main;           // Write to main register
  logic       wr_exp;            // Write to expansion register
  logic [7:0] mem_size_select;   // Main register contents
  logic [7:0] expansion_ram_size_select;  // Expansion register contents
  logic [7:0] next_mem_size_select;       // Main value after this edge
  logic [7:0] next_expansion_ram_size_select;  // Expansion value after edge

  // Only exact byte addresses hit; the bus is one byte wide throughout
  always_comb
  begin
    sel_main = (bus_req.addr == MSC_MEM_SIZE_SEL_ADDR);
    sel_exp  = (bus_req.addr == MSC_EXP_SIZE_SEL_ADDR);
    wr_main  = bus_req.wr && sel_main;
    wr_exp   = bus_req.wr && sel_exp;
  end

  ////////////////////////////////////////////////////////////////////////
  // The two registers
  // Main register: bit 4 stays zero whatever is written
  msc_size_reg #(
    .RESET_VAL (MSC_MEM_SIZE_SEL_RST),
    .WR_MASK   (MSC_MEM_SIZE_SEL_MASK)
  ) u_mem_size_select (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wr_en      (wr_main),
    .wr_data    (bus_req.wdata),
    .value      (mem_size_select),
    .next_value (next_mem_size_select)
  );

  // Expansion register: only the low nibble is kept
  msc_size_reg #(
    .RESET_VAL (MSC_EXP_SIZE_SEL_RST),
    .WR_MASK   (MSC_EXP_SIZE_SEL_MASK)
  ) u_expansion_ram_size_select (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wr_en      (wr_exp),
    .wr_data    (bus_req.wdata),
    .value      (expansion_ram_size_select),
    .next_value (next_expansion_ram_size_select)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read port
  logic       next_rd_valid;  // Answer strobe
  logic       next_rd_hit;    // Answer came from a mapped address
  logic [7:0] next_rd_data;   // Answer byte

  // Answer one cycle after the strobe; unmapped addresses read zero
  always_comb
  begin
    next_rd_valid = bus_req.rd;
    next_rd_hit   = 1'b0;
    next_rd_data  = 8'h00;
    if (bus_req.rd)
    begin
      if (sel_main)
      begin
        next_rd_hit  = 1'b1;
        next_rd_data = mem_size_select;
      end
      else if (sel_exp)
      begin
        next_rd_hit  = 1'b1;
        next_rd_data = expansion_ram_size_select;
      end
      else
      begin
        next_rd_data = 8'h00;
      end
    end
  end

  // Answer registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
      rd_data  <= 8'h00;
    end
    else
    begin
      rd_valid <= next_rd_valid;
      rd_hit   <= next_rd_hit;
      rd_data  <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capacity decode
  // Decoding the next register values lets the outputs come from
  // flip-flops yet still change on the very edge that takes the write.
  logic [2:0] hs_code;    // RAM field
  logic [3:0] rom_code;   // ROM field
  logic [3:0] exp_code;   // Expansion field
  msc_cfg_t   next_mem_cfg;  // Decoded capacities after this edge

  always_comb
  begin
    hs_code  = next_mem_size_select[MSC_HS_RAM_LSB +: 3];
    rom_code = next_mem_size_select[MSC_PROG_ROM_LSB +: 4];
    exp_code = next_expansion_ram_size_select[MSC_EXP_RAM_LSB +: 4];

    // Prohibited codes decode to zero size and drop the ok flag
    next_mem_cfg = '0;

    if (hs_code == MSC_HS_RAM_1K)
    begin
      next_mem_cfg.hs_ram_bytes = MSC_HS_RAM_BYTES_1K;
      next_mem_cfg.hs_ram_ok    = 1'b1;
    end

    case (rom_code)
      MSC_ROM_32K:
      begin
        next_mem_cfg.rom_bytes = MSC_ROM_BYTES_32K;
        next_mem_cfg.rom_ok    = 1'b1;
      end
      MSC_ROM_48K:
      begin
        next_mem_cfg.rom_bytes = MSC_ROM_BYTES_48K;
        next_mem_cfg.rom_ok    = 1'b1;
      end
      MSC_ROM_60K:
      begin
        next_mem_cfg.rom_bytes = MSC_ROM_BYTES_60K;
        next_mem_cfg.rom_ok    = 1'b1;
      end
      default:
      begin
        // Software is trusted to avoid these; flagged, not repaired
        next_mem_cfg.rom_ok = 1'b0;
      end
    endcase

    case (exp_code)
      MSC_EXP_RAM_0:
      begin
        next_mem_cfg.exp_ram_bytes = 12'h000;
        next_mem_cfg.exp_ok        = 1'b1;
      end
      MSC_EXP_RAM_1K:
      begin
        next_mem_cfg.exp_ram_bytes = MSC_EXP_BYTES_1K;
        next_mem_cfg.exp_ok        = 1'b1;
      end
      MSC_EXP_RAM_2K:
      begin
        next_mem_cfg.exp_ram_bytes = MSC_EXP_BYTES_2K;
        next_mem_cfg.exp_ok        = 1'b1;
      end
      default:
      begin
        next_mem_cfg.exp_ok = 1'b0;
      end
    endcase

    // Overlap is only reported, the memories still use the settings
    next_mem_cfg.overlap = (next_mem_cfg.exp_ram_bytes != 12'h000)
                        && (next_mem_cfg.rom_bytes > EXP_RAM_BASE);
  end

  // Decoded capacity registers, reset to the decode of the reset values
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mem_cfg               <= '0;
      mem_cfg.hs_ram_bytes  <= MSC_HS_RAM_BYTES_1K;
      mem_cfg.rom_bytes     <= MSC_ROM_BYTES_60K;
      mem_cfg.exp_ram_bytes <= 12'h000;
      mem_cfg.hs_ram_ok     <= 1'b1;
      mem_cfg.rom_ok        <= 1'b1;
      mem_cfg.exp_ok        <= 1'b1;
    end
    else
    begin
      mem_cfg <= next_mem_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write order tracking
  // Watches that the main register is set before the expansion one.
  msc_order_t order_state;       // Current step
  msc_order_t next_order_state;  // Step after this edge
  logic       next_order_error;  // Sticky order fault
  logic       next_cfg_done;     // Both written in order

  always_comb
  begin
    next_order_state = order_state;
    next_order_error = order_error;
    case (order_state)
      MSC_ST_FRESH:
      begin
        if (wr_main)
        begin
          next_order_state = MSC_ST_MAIN_SET;
        end
        else if (wr_exp)
        begin
          next_order_error = 1'b1;
        end
      end
      MSC_ST_MAIN_SET:
      begin
        if (wr_exp)
        begin
          next_order_state = MSC_ST_ALL_SET;
        end
      end
      MSC_ST_ALL_SET:
      begin
        // A new main write reopens the sequence
        if (wr_main)
        begin
          next_order_state = MSC_ST_MAIN_SET;
        end
      end
      default:
      begin
        next_order_state = MSC_ST_FRESH;
      end
    endcase
    next_cfg_done = (next_order_state == MSC_ST_ALL_SET);
  end

  // Order registers; the fault is cleared only by reset
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      order_state <= MSC_ST_FRESH;
      order_error <= 1'b0;
      cfg_done    <= 1'b0;
    end
    else
    begin
      order_state <= next_order_state;
      order_error <= next_order_error;
      cfg_done    <= next_cfg_done;
    end
  end

endmodule : msc_mem_size_cfg

// File: msc_pkg.sv
// Constants and carriers shared by the memory size configuration block.
// Assumes one system clock and a byte-wide internal memory-mapped bus.
package msc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the internal bus
  localparam logic [15:0] MSC_MEM_SIZE_SEL_ADDR = 16'hFFF0;  // Main size select
  localparam logic [15:0] MSC_EXP_SIZE_SEL_ADDR = 16'hFFF4;  // Expansion size select

  // Values after reset
  localparam logic [7:0] MSC_MEM_SIZE_SEL_RST = 8'hCF;  // 1024 B RAM, 60 KB ROM
  localparam logic [7:0] MSC_EXP_SIZE_SEL_RST = 8'h0C;  // No expansion RAM

  // Writable bits; others are fixed at zero
  localparam logic [7:0] MSC_MEM_SIZE_SEL_MASK = 8'hEF;  // Bit 4 fixed zero
  localparam logic [7:0] MSC_EXP_SIZE_SEL_MASK = 8'h0F;  // Bits 7..4 fixed zero

  // Field positions
  localparam int MSC_HS_RAM_LSB   = 5;  // Bits 7..5
  localparam int MSC_PROG_ROM_LSB = 0;  // Bits 3..0
  localparam int MSC_EXP_RAM_LSB  = 0;  // Bits 3..0

  ////////////////////////////////////////////////////////////////////////
  // Capacity codes
  localparam logic [2:0] MSC_HS_RAM_1K   = 3'h6;  // 1024 bytes
  localparam logic [3:0] MSC_ROM_32K     = 4'h8;  // 32 KB
  localparam logic [3:0] MSC_ROM_48K     = 4'hC;  // 48 KB
  localparam logic [3:0] MSC_ROM_60K     = 4'hF;  // 60 KB
  localparam logic [3:0] MSC_EXP_RAM_0   = 4'hC;  // 0 bytes
  localparam logic [3:0] MSC_EXP_RAM_1K  = 4'hA;  // 1024 bytes
  localparam logic [3:0] MSC_EXP_RAM_2K  = 4'h8;  // 2048 bytes

  // Capacities in bytes
  localparam logic [10:0] MSC_HS_RAM_BYTES_1K  = 11'h400;
  localparam logic [16:0] MSC_ROM_BYTES_32K    = 17'h08000;
  localparam logic [16:0] MSC_ROM_BYTES_48K    = 17'h0C000;
  localparam logic [16:0] MSC_ROM_BYTES_60K    = 17'h0F000;
  localparam logic [11:0] MSC_EXP_BYTES_1K     = 12'h400;
  localparam logic [11:0] MSC_EXP_BYTES_2K     = 12'h800;

  // Default start of the expansion RAM window
  localparam logic [16:0] MSC_EXP_BASE_DEFAULT = 17'h0C000;

  ////////////////////////////////////////////////////////////////////////
  // Byte access from the processor side
  typedef struct packed {
    logic        rd;     // Read strobe, one cycle
    logic        wr;     // Write strobe, one cycle
    logic [15:0] addr;   // Byte address
    logic [7:0]  wdata;  // Write byte
  } msc_bus_req_t;

  // Decoded capacities handed to the memory controllers
  typedef struct packed {
    logic [10:0] hs_ram_bytes;   // High-speed RAM size
    logic [16:0] rom_bytes;      // Program store size
    logic [11:0] exp_ram_bytes;  // Expansion RAM size
    logic        hs_ram_ok;      // RAM code is a listed one
    logic        rom_ok;         // ROM code is a listed one
    logic        exp_ok;         // Expansion code is a listed one
    logic        overlap;        // ROM runs into expansion RAM
  } msc_cfg_t;

  // Write-order tracking states, one-hot
  typedef enum logic [2:0] {
    MSC_ST_FRESH    = 3'b001,  // Main register not written since reset
    MSC_ST_MAIN_SET = 3'b010,  // Main register written
    MSC_ST_ALL_SET  = 3'b100   // Expansion written after main
  } msc_order_t;

endpackage : msc_pkg

// File: msc_size_reg.sv
// One byte-wide size select register with fixed-zero bits.
// Assumes the write strobe comes from logic on the same clock.
`timescale 1ns/1ns
module msc_size_reg
  import msc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,  // Value after reset
  parameter logic [7:0] WR_MASK   = 8'hFF   // Writable bits
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Register contents
  output logic      [7:0] value,
  output logic      [7:0] next_value
);

  ////////////////////////////////////////////////////////////////////////
  // A reset value with fixed bits set could never be written back
  if ((RESET_VAL & ~WR_MASK) != 8'h00)
  begin : g_bad_reset
    $error("msc_size_reg: reset value sets a fixed-zero bit");
  end

  ////////////////////////////////////////////////////////////////////////
  // Next value: whole byte replaced, fixed bits forced low
  always_comb
  begin
    next_value = value;
    if (wr_en)
    begin
      next_value = wr_data & WR_MASK;
    end
  end

  // Storage
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      value <= RESET_VAL;
    end
    else
    begin
      value <= next_value;
    end
  end

endmodule : msc_size_reg

// File: msc_mem_size_cfg_properties.sv
// Checker for the memory size configuration block, watching top ports only.
// Assumes one clock domain and the synchronous active-low reset nrst.
`timescale 1ns/1ns
module msc_mem_size_cfg_properties
  import msc_pkg::*;
#(
  parameter logic [16:0] EXP_RAM_BASE = MSC_EXP_BASE_DEFAULT  // Expansion window start
)
(
  // Clock and reset
  input wire logic         sys_clk,
  input wire logic         nrst,
  // Processor byte bus
  input wire msc_bus_req_t bus_req,
  input wire logic         rd_valid,
  input wire logic         rd_hit,
  input wire logic   [7:0] rd_data,
  // Status
  input wire msc_cfg_t     mem_cfg,
  input wire logic         order_error,
  input wire logic         cfg_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////
  // Access decode helpers
  logic       wr_main;   // Write to main register
  logic       wr_exp;    // Write to expansion register
  logic       rd_main;   // Read of main register
  logic       rd_exp;    // Read of expansion register
  logic       rd_other;  // Read of an unmapped byte
  logic [7:0] wd;        // Write byte, plain signal for $past
  assign wr_main  = bus_req.wr && (bus_req.addr == 16'hFFF0);
  assign wr_exp   = bus_req.wr && (bus_req.addr == 16'hFFF4);
  assign rd_main  = bus_req.rd && (bus_req.addr == 16'hFFF0);
  assign rd_exp   = bus_req.rd && (bus_req.addr == 16'hFFF4);
  assign rd_other = bus_req.rd && !rd_main && !rd_exp;
  assign wd       = bus_req.wdata;

  // Kept apart from the design decode so a shared slip cannot hide
  function automatic logic [16:0] rom_of(input logic [7:0] v);
    case (v[3:0])
      4'h8: return 17'h08000;
      4'hC: return 17'h0C000;
      4'hF: return 17'h0F000;
      default: return 17'h00000;
    endcase
  endfunction : rom_of

  function automatic logic [11:0] exp_of(input logic [7:0] v);
    case (v[3:0])
      4'hA: return 12'h400;
      4'h8: return 12'h800;
      default: return 12'h000;
    endcase
  endfunction : exp_of

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_read_latency: assert property (bus_req.rd |=> rd_valid)
    else $error("read not answered one cycle later");
  a_read_quiet: assert property (!bus_req.rd |=> !rd_valid && rd_data == 8'h00)
    else $error("read answer without a read");
  a_main_fixed_bit: assert property (rd_main |=> rd_hit && !rd_data[4])
    else $error("main register read wrong");
  a_exp_upper_zero: assert property (rd_exp |=> rd_hit && rd_data[7:4] == 4'h0)
    else $error("expansion register read wrong");
  a_unmapped_read: assert property (rd_other |=> !rd_hit && rd_data == 8'h00)
    else $error("unmapped read answered as mapped");
  a_reset_values: assert property ($rose(nrst) |->
    mem_cfg == {11'h400, 17'h0F000, 12'h000, 4'b1110} && !order_error && !cfg_done)
    else $error("decode wrong after reset");
  a_rom_decode: assert property (wr_main |=> mem_cfg.rom_bytes == rom_of($past(wd)))
    else $error("program store size wrong");
  a_hs_decode: assert property (wr_main |=> mem_cfg.hs_ram_ok == ($past(wd[7:5]) == 3'h6)
    && mem_cfg.hs_ram_bytes == (($past(wd[7:5]) == 3'h6) ? 11'h400 : 11'h000))
    else $error("high-speed RAM size wrong");
  a_exp_decode: assert property (wr_exp |=> mem_cfg.exp_ram_bytes == exp_of($past(wd)))
    else $error("expansion RAM size wrong");
  a_cfg_hold: assert property (!bus_req.wr |=> $stable(mem_cfg))
    else $error("decode changed without a write");
  a_overlap_flag: assert property (mem_cfg.overlap ==
    ((mem_cfg.exp_ram_bytes != 12'h000) && (mem_cfg.rom_bytes > EXP_RAM_BASE)))
    else $error("overlap flag wrong");
  a_order_seen: assert property (wr_exp |=> cfg_done || order_error)
    else $error("expansion write left no order status");
  a_main_clears_done: assert property (wr_main && !wr_exp |=> !cfg_done)
    else $error("main write kept done flag");

  // Main scenarios reached
  c_main_write: cover property (wr_main);
  c_exp_read: cover property (rd_exp ##1 rd_valid);
  c_unmapped: cover property (rd_other ##1 !rd_hit);
endmodule : msc_mem_size_cfg_properties

bind msc_mem_size_cfg msc_mem_size_cfg_properties #(.EXP_RAM_BASE(EXP_RAM_BASE)) u_props (
  .sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .rd_valid(rd_valid), .rd_hit(rd_hit),
  .rd_data(rd_data), .mem_cfg(mem_cfg), .order_error(order_error), .cfg_done(cfg_done));

// File: tb_top.sv
// Self-checking bench for the memory size configuration block.
// Assumes default expansion base; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_top;
  import msc_pkg::*;
  logic         sys_clk;      // 25 MHz clock
  logic         nrst;         // Synchronous reset, active low
  msc_bus_req_t bus_req;      // Processor byte bus
  logic         rd_valid;     // Read answer strobe
  logic         rd_hit;       // Mapped address
  logic   [7:0] rd_data;      // Read byte
  msc_cfg_t     mem_cfg;      // Decoded capacities
  logic         order_error;  // Sticky order fault
  logic         cfg_done;     // Ordered setup seen
  int           n_mismatch;   // Failed comparisons
  int           num_checks;   // All comparisons
  logic   [7:0] main_v;       // Expected main register
  logic   [7:0] exp_v;        // Expected expansion register
  logic   [7:0] main_tab [3] = '{8'hC8, 8'hCC, 8'hCF};
  logic   [7:0] exp_tab  [4] = '{8'h0C, 8'h0A, 8'h08, 8'hFF};

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  msc_mem_size_cfg dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .rd_data(rd_data), .mem_cfg(mem_cfg), .order_error(order_error), .cfg_done(cfg_done));

  ////////////////////////////////////////////////////////////////////////
  // Expected decode, written from the capacity tables
  function automatic msc_cfg_t cfg_exp(input logic [7:0] m, input logic [7:0] x);
    msc_cfg_t c;
    c = '0;
    c.hs_ram_ok = (m[7:5] == 3'h6);
    c.hs_ram_bytes = c.hs_ram_ok ? 11'h400 : 11'h000;
    c.rom_bytes = (m[3:0] == 4'h8) ? 17'h08000 : (m[3:0] == 4'hC) ? 17'h0C000 :
                  (m[3:0] == 4'hF) ? 17'h0F000 : 17'h00000;
    c.rom_ok = (c.rom_bytes != 17'h00000);
    c.exp_ram_bytes = (x[3:0] == 4'hA) ? 12'h400 : (x[3:0] == 4'h8) ? 12'h800 : 12'h000;
    c.exp_ok = (x[3:0] == 4'hC) || (c.exp_ram_bytes != 12'h000);
    // Window starts at the default base of 0C000
    c.overlap = (c.exp_ram_bytes != 12'h000) && (c.rom_bytes > 17'h0C000);
    return c;
  endfunction : cfg_exp

  task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks: one strobe cycle, answer looked at on the next falling edge
  task do_reset;
    nrst = 1'b0;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    main_v = 8'hCF;
    exp_v = 8'h0C;
  endtask : do_reset

  task wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(negedge sys_clk);
    bus_req.wr = 1'b0;
    if (a == 16'hFFF0) main_v = d & 8'hEF;
    if (a == 16'hFFF4) exp_v = d & 8'h0F;
    check("mem_cfg", mem_cfg, cfg_exp(main_v, exp_v));
  endtask : wr_byte

  task rd_byte(input logic [15:0] a, input logic hit, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(negedge sys_clk);
    bus_req.rd = 1'b0;
    check("rd_valid", rd_valid, 1'b1);
    check("rd_hit", rd_hit, hit);
    check("rd_data", rd_data, d);
  endtask : rd_byte

  task end_of_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    nrst = 1'b0;
    bus_req = '0;
    do_reset();
    check("mem_cfg", mem_cfg, cfg_exp(8'hCF, 8'h0C));
    rd_byte(16'hFFF0, 1'b1, 8'hCF);
    rd_byte(16'hFFF4, 1'b1, 8'h0C);
    // Expansion first: order fault is flagged
    wr_byte(16'hFFF4, 8'h0A);
    check("order_error", order_error, 1'b1);
    do_reset();
    check("order_error", order_error, 1'b0);
    // Every listed main code against every listed expansion code and one prohibited one
    for (int i = 0; i < 3; i++)
    begin
      wr_byte(16'hFFF0, main_tab[i]);
      check("cfg_done", cfg_done, 1'b0);
      rd_byte(16'hFFF0, 1'b1, main_tab[i]);
      for (int j = 0; j < 4; j++)
      begin
        wr_byte(16'hFFF4, exp_tab[j]);
        check("cfg_done", cfg_done, 1'b1);
        rd_byte(16'hFFF4, 1'b1, exp_tab[j] & 8'h0F);
      end
    end
    check("order_error", order_error, 1'b0);
    // Fixed bit and prohibited RAM code
    wr_byte(16'hFFF0, 8'hFF);
    rd_byte(16'hFFF0, 1'b1, 8'hEF);
    // Unmapped bytes neither store nor hit; their reads answer zero
    wr_byte(16'hFFF2, 8'h00);
    rd_byte(16'hFFF2, 1'b0, 8'h00);
    rd_byte(16'hFFF1, 1'b0, 8'h00);
    rd_byte(16'hFFF0, 1'b1, 8'hEF);
    // Read and write in one cycle: old byte answers, new byte is stored
    @(negedge sys_clk);
    bus_req.rd = 1'b1;
    bus_req.wr = 1'b1;
    bus_req.addr = 16'hFFF0;
    bus_req.wdata = 8'hC8;
    @(negedge sys_clk);
    bus_req.rd = 1'b0;
    bus_req.wr = 1'b0;
    main_v = 8'hC8;
    check("rd_data", rd_data, 8'hEF);
    check("mem_cfg", mem_cfg, cfg_exp(main_v, exp_v));
    check("cfg_done", cfg_done, 1'b0);
    rd_byte(16'hFFF0, 1'b1, 8'hC8);
    end_of_test();
  end
endmodule : tb_top
